// ---- logic/fdlcd_pkg.sv ----
// Purpose: constants for the four-digit LCD latch decoder core
// Assumes: single 200 MHz clock, synchronous active-high reset
// Notes: segment order in every 7-bit pattern is {g,f,e,d,c,b,a}
//
// Notes on behaviour
// - Address 00 picks fourth digit, 01 third, 10 second, 11 first.
// - While both selects are low, value and address are captured.
// - Rising edge of the first select to rise after both were low decodes and stores into addressed digit.
// - Value is true binary, weights one, two, four, eight.
// - Values 0-9 decimal; 10-15 dash, E, H, L, P, blank.
// - Seven segments per digit, 28 total, plus one backplane driver.
// - Backplane is the oscillator divided by 128.
// - Nominal 19 kHz oscillator gives about 150 Hz backplane.
// - Oscillator input low disables backplane driver; segments follow external line.
// - Oscillator lows shorter than about one microsecond are ignored.
`default_nettype none
package fdlcd_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OSC_DIV = 128;
  localparam int unsigned OSC_HALF_DIV = OSC_DIV / 2;
  localparam int unsigned OSC_NOM_HZ = 19000;
  localparam int unsigned OSC_HALF_CYC = (CLK_MHZ * 1000000) / (2 * OSC_NOM_HZ);
  localparam int unsigned LOW_IGNORE_NS = 1000;
  localparam int unsigned LOW_IGNORE_CYC = (LOW_IGNORE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SEG_W = 7;
  localparam int unsigned NUM_DIGITS = 4;
  localparam logic [1:0] ADDR_FIRST = 2'h3;
  localparam logic [1:0] ADDR_SECOND = 2'h2;
  localparam logic [1:0] ADDR_THIRD = 2'h1;
  localparam logic [1:0] ADDR_FOURTH = 2'h0;
  localparam logic [6:0] SEG_RESET = 7'h00;
  localparam logic [6:0] SEG_0 = 7'h3F;
  localparam logic [6:0] SEG_1 = 7'h06;
  localparam logic [6:0] SEG_2 = 7'h5B;
  localparam logic [6:0] SEG_3 = 7'h4F;
  localparam logic [6:0] SEG_4 = 7'h66;
  localparam logic [6:0] SEG_5 = 7'h6D;
  localparam logic [6:0] SEG_6 = 7'h7D;
  localparam logic [6:0] SEG_7 = 7'h07;
  localparam logic [6:0] SEG_8 = 7'h7F;
  localparam logic [6:0] SEG_9 = 7'h6F;
  localparam logic [6:0] SEG_DASH = 7'h40;
  localparam logic [6:0] SEG_E = 7'h79;
  localparam logic [6:0] SEG_H = 7'h76;
  localparam logic [6:0] SEG_L = 7'h38;
  localparam logic [6:0] SEG_P = 7'h73;
  localparam logic [6:0] SEG_BLANK = 7'h00;
endpackage : fdlcd_pkg
`default_nettype wire

// ---- logic/fdlcd_decode.sv ----
// Purpose: binary value to seven-segment pattern
// Assumes: value bit 0 has weight one
// Notes: purely combinational
`default_nettype none
`timescale 1ns/100ps
module fdlcd_decode (
  input wire logic [3:0] value,
  output logic [6:0] pattern
);
  import fdlcd_pkg::*;
  always_comb begin
    unique case (value)
      4'h0: pattern = SEG_0;
      4'h1: pattern = SEG_1;
      4'h2: pattern = SEG_2;
      4'h3: pattern = SEG_3;
      4'h4: pattern = SEG_4;
      4'h5: pattern = SEG_5;
      4'h6: pattern = SEG_6;
      4'h7: pattern = SEG_7;
      4'h8: pattern = SEG_8;
      4'h9: pattern = SEG_9;
      4'hA: pattern = SEG_DASH;
      4'hB: pattern = SEG_E;
      4'hC: pattern = SEG_H;
      4'hD: pattern = SEG_L;
      4'hE: pattern = SEG_P;
      4'hF: pattern = SEG_BLANK;
    endcase
  end
endmodule : fdlcd_decode
`default_nettype wire

// ---- logic/fdlcd_core.sv ----
// Purpose: four-digit LCD latch decoder-driver core
// Assumes: all pins synchronous to mclk; oscillator input sampled as a level
// Notes: a free-running mclk counter giving one tick per half period models the on-chip RC oscillator
`default_nettype none
`timescale 1ns/100ps
module fdlcd_core #(
  parameter int unsigned OSC_HALF = fdlcd_pkg::OSC_HALF_CYC,
  parameter int unsigned LOW_IGN = fdlcd_pkg::LOW_IGNORE_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic value_bit_ones,
  input wire logic value_bit_twos,
  input wire logic value_bit_fours,
  input wire logic value_bit_eights,
  input wire logic digit_sel_low_bit,
  input wire logic digit_sel_high_bit,
  input wire logic select_strobe_a_n,
  input wire logic select_strobe_b_n,
  input wire logic osc_in,
  input wire logic common_plane_line_in,
  output logic common_plane_line_out,
  output logic common_plane_line_oe,
  output logic [6:0] digit_first,
  output logic [6:0] digit_second,
  output logic [6:0] digit_third,
  output logic [6:0] digit_fourth
);
  import fdlcd_pkg::*;

  // osc_cnt and low_cnt are 16 bits wide, so larger counts cannot be served
  if (OSC_HALF < 1 || LOW_IGN < 1 || LOW_IGN > 65535 || OSC_HALF > 65535) begin : g_bad_count
    $error("fdlcd_core: count parameter out of range");
  end

  // ==========================================
  // Input latches
  logic [3:0] value_latch;
  logic [1:0] addr_latch;
  logic both_low;
  logic both_low_d;
  logic write_edge;
  logic [6:0] pattern;
  assign both_low = ~select_strobe_a_n & ~select_strobe_b_n;
  // Joint-low ending is the rising edge of whichever select went first
  assign write_edge = both_low_d & ~both_low;

  always_ff @(posedge mclk) begin
    if (srst) begin
      value_latch <= 4'h0;
      addr_latch <= 2'h0;
      both_low_d <= 1'b0;
    end else begin
      both_low_d <= both_low;
      if (both_low) begin
        value_latch <= {value_bit_eights, value_bit_fours, value_bit_twos, value_bit_ones};
        addr_latch <= {digit_sel_high_bit, digit_sel_low_bit};
      end
    end
  end

  fdlcd_decode u_dec (
    .value(value_latch),
    .pattern(pattern)
  );

  // ==========================================
  // Digit output latches
  logic [6:0] store [NUM_DIGITS];
  logic [1:0] addr_idx [NUM_DIGITS];
  assign addr_idx[0] = ADDR_FIRST;
  assign addr_idx[1] = ADDR_SECOND;
  assign addr_idx[2] = ADDR_THIRD;
  assign addr_idx[3] = ADDR_FOURTH;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_dig
      always_ff @(posedge mclk) begin
        if (srst) begin
          store[gi] <= SEG_RESET;
        end else if (write_edge && addr_latch == addr_idx[gi]) begin
          store[gi] <= pattern;
        end
      end
    end
  endgenerate

  // ==========================================
  // Oscillator model and divide-by-128 chain
  logic [15:0] osc_cnt;
  logic osc_tick;
  logic [6:0] div_cnt;
  logic plane_int;
  assign osc_tick = (osc_cnt == 16'(OSC_HALF - 1));

  // A tick is half an oscillator period: 128 ticks make one plane half period
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_cnt <= 16'h0000;
      div_cnt <= 7'h00;
      plane_int <= 1'b0;
    end else begin
      osc_cnt <= osc_tick ? 16'h0000 : osc_cnt + 16'h0001;
      if (osc_tick) begin
        div_cnt <= div_cnt + 7'h01;
        if (div_cnt == 7'(OSC_DIV - 1)) begin
          plane_int <= ~plane_int;
        end
      end
    end
  end

  // ==========================================
  // Backplane disable sensing
  // Short lows are filtered so an overdriving clock cannot cause DC drive
  logic [15:0] low_cnt;
  logic slave_mode;
  always_ff @(posedge mclk) begin
    if (srst) begin
      low_cnt <= 16'h0000;
      slave_mode <= 1'b0;
    end else if (osc_in) begin
      low_cnt <= 16'h0000;
      slave_mode <= 1'b0;
    end else if (low_cnt < 16'(LOW_IGN)) begin
      low_cnt <= low_cnt + 16'h0001;
    end else begin
      slave_mode <= 1'b1;
    end
  end

  // ==========================================
  // Drivers
  logic plane_ref;
  assign plane_ref = slave_mode ? common_plane_line_in : plane_int;

  always_ff @(posedge mclk) begin
    if (srst) begin
      common_plane_line_out <= 1'b0;
      common_plane_line_oe <= 1'b0;
      digit_first <= SEG_RESET;
      digit_second <= SEG_RESET;
      digit_third <= SEG_RESET;
      digit_fourth <= SEG_RESET;
    end else begin
      common_plane_line_out <= plane_int;
      common_plane_line_oe <= ~slave_mode;
      digit_first <= store[0] ^ {SEG_W{plane_ref}};
      digit_second <= store[1] ^ {SEG_W{plane_ref}};
      digit_third <= store[2] ^ {SEG_W{plane_ref}};
      digit_fourth <= store[3] ^ {SEG_W{plane_ref}};
    end
  end

  // ==========================================
  // Assertions
  property p_write_first;
    @(posedge mclk) disable iff (srst)
      (write_edge && addr_latch == ADDR_FIRST) |=> (store[0] == $past(pattern));
  endproperty
  a_write_first: assert property (p_write_first) else $error("first digit not written");

  property p_write_fourth;
    @(posedge mclk) disable iff (srst)
      (write_edge && addr_latch == ADDR_FOURTH) |=> (store[3] == $past(pattern));
  endproperty
  a_write_fourth: assert property (p_write_fourth) else $error("fourth digit not written");

  property p_capture;
    @(posedge mclk) disable iff (srst)
      both_low |=> (value_latch == $past({value_bit_eights, value_bit_fours, value_bit_twos, value_bit_ones}));
  endproperty
  a_capture: assert property (p_capture) else $error("value not captured");

  property p_hold;
    @(posedge mclk) disable iff (srst)
      !(write_edge && addr_latch == ADDR_SECOND) |=> $stable(store[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("second digit changed without write");

  property p_blank;
    @(posedge mclk) disable iff (srst)
      (value_latch == 4'hF) |-> (pattern == SEG_BLANK);
  endproperty
  a_blank: assert property (p_blank) else $error("code 15 not blank");

  property p_filter;
    @(posedge mclk) disable iff (srst)
      $rose(slave_mode) |-> $past(!osc_in, 2) && $past(!osc_in, 1);
  endproperty
  a_filter: assert property (p_filter) else $error("slave mode on short low");

  property p_disable;
    @(posedge mclk) disable iff (srst)
      slave_mode |=> !common_plane_line_oe;
  endproperty
  a_disable: assert property (p_disable) else $error("backplane driven in slave mode");

  property p_phase;
    @(posedge mclk) disable iff (srst)
      1'b1 |=> (digit_third == ($past(store[2]) ^ {SEG_W{$past(plane_ref)}}));
  endproperty
  a_phase: assert property (p_phase) else $error("segment phase wrong");

  property p_div;
    @(posedge mclk) disable iff (srst)
      (osc_tick && div_cnt != 7'(OSC_DIV - 1)) |=> $stable(plane_int);
  endproperty
  a_div: assert property (p_div) else $error("backplane toggled early");

  property p_div_toggle;
    @(posedge mclk) disable iff (srst)
      (osc_tick && div_cnt == 7'(OSC_DIV - 1)) |=> (plane_int != $past(plane_int));
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("backplane did not toggle");

  property p_filter_count;
    @(posedge mclk) disable iff (srst)
      $rose(slave_mode) |-> ($past(low_cnt) == 16'(LOW_IGN));
  endproperty
  a_filter_count: assert property (p_filter_count) else $error("slave mode before full low time");

  property p_master_drive;
    @(posedge mclk) disable iff (srst)
      !slave_mode |=> (common_plane_line_oe && common_plane_line_out == $past(plane_int));
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("backplane not driven in master mode");

  c_write: cover property (@(posedge mclk) disable iff (srst) write_edge);
  c_slave: cover property (@(posedge mclk) disable iff (srst) $rose(slave_mode));
  c_plane: cover property (@(posedge mclk) disable iff (srst) $rose(plane_int));
  c_first: cover property (@(posedge mclk) disable iff (srst) write_edge && addr_latch == ADDR_FIRST);
endmodule : fdlcd_core
`default_nettype wire

// ---- tb/fdlcd_host_model.sv ----
// Purpose: host bus model writing digits through the select strobes
// Assumes: strobes and data change just after mclk rising edges
// Notes: released data lines show the inverted last value
`default_nettype none
`timescale 1ns/100ps
module fdlcd_host_model (
  input wire logic mclk,
  output logic [3:0] value,
  output logic [1:0] addr,
  output logic sel_a_n,
  output logic sel_b_n
);
  localparam int LOW_CYC = 40;
  localparam int GAP_CYC = 400;
  initial begin
    value = 4'h0;
    addr = 2'h0;
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
  end
  // ==========================================
  // Write cycle
  // Mode 0 releases strobe a first, 1 strobe b, 2 lowers only strobe a
  task automatic write(input logic [3:0] v, input logic [1:0] a, input int mode);
    @(posedge mclk);
    value <= v;
    addr <= a;
    sel_a_n <= 1'b0;
    sel_b_n <= (mode == 2);
    repeat (LOW_CYC) @(posedge mclk);
    if (mode == 1) sel_b_n <= 1'b1;
    else sel_a_n <= 1'b1;
    @(posedge mclk);
    sel_a_n <= 1'b1;
    sel_b_n <= 1'b1;
    value <= ~v;
    addr <= ~a;
    repeat (GAP_CYC) @(posedge mclk);
  endtask : write
endmodule : fdlcd_host_model
`default_nettype wire

// ---- tb/fdlcd_core_tb.sv ----
// Purpose: self-checking bench for the LCD latch decoder core
// Assumes: shortened oscillator and low-filter counts
// Notes: segments are compared after removing the plane phase
`default_nettype none
`timescale 1ns/100ps
module fdlcd_core_tb;
  import fdlcd_pkg::*;
  localparam int unsigned OSC_H = 2;
  localparam int unsigned LOW_I = 4;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic osc_in = 1'b1;
  logic ext_plane = 1'b0;
  wire [3:0] value;
  wire [1:0] addr;
  wire sel_a_n;
  wire sel_b_n;
  wire plane_wire;
  logic plane_out;
  logic plane_oe;
  logic [6:0] dig [4];
  logic [6:0] exp_dig [4];
  logic [6:0] codes [16] = '{SEG_0, SEG_1, SEG_2, SEG_3, SEG_4, SEG_5, SEG_6, SEG_7,
    SEG_8, SEG_9, SEG_DASH, SEG_E, SEG_H, SEG_L, SEG_P, SEG_BLANK};
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int t0;
  always #2.5 mclk = ~mclk;
  // Shared plane line: the device drives it only while enabled
  assign plane_wire = plane_oe ? plane_out : ext_plane;
  fdlcd_host_model host (.mclk(mclk), .value(value), .addr(addr), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n));
  fdlcd_core #(.OSC_HALF(OSC_H), .LOW_IGN(LOW_I)) DUT (.mclk(mclk), .srst(srst),
    .value_bit_ones(value[0]), .value_bit_twos(value[1]), .value_bit_fours(value[2]),
    .value_bit_eights(value[3]), .digit_sel_low_bit(addr[0]), .digit_sel_high_bit(addr[1]),
    .select_strobe_a_n(sel_a_n), .select_strobe_b_n(sel_b_n), .osc_in(osc_in),
    .common_plane_line_in(plane_wire), .common_plane_line_out(plane_out),
    .common_plane_line_oe(plane_oe), .digit_first(dig[3]), .digit_second(dig[2]),
    .digit_third(dig[1]), .digit_fourth(dig[0]));
  // ==========================================
  // Checking and closing
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, expv, seen);
    end
  endtask : check
  // Sample away from a plane toggle so segments and plane agree
  task automatic check_digits();
    logic p;
    p = plane_out;
    repeat (3) @(negedge mclk);
    if (plane_out !== p) repeat (3) @(negedge mclk);
    for (int i = 0; i < 4; i++) check("digit", 16'(dig[i] ^ {7{plane_out}}), 16'(exp_dig[i]));
  endtask : check_digits
  task automatic end_of_test();
    $display("Compared %0d, mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("BAD timeout expected done seen hang");
      end_of_test();
    end
  end
  // ==========================================
  // Tests
  initial begin
    exp_dig = '{default: SEG_RESET};
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    check_digits();
    $display("test reset done");
    for (int v = 0; v < 16; v++) begin
      host.write(v[3:0], v[1:0], v % 2);
      exp_dig[v % 4] = codes[v];
      check_digits();
    end
    host.write(4'h8, 2'h0, 2);
    check_digits();
    $display("test writes done");
    @(posedge plane_out);
    t0 = cycles;
    @(negedge plane_out);
    check("plane half period", 16'(cycles - t0), 16'(OSC_H * OSC_DIV));
    @(posedge mclk);
    osc_in <= 1'b0;
    repeat (LOW_I - 1) @(posedge mclk);
    osc_in <= 1'b1;
    repeat (10) begin
      @(negedge mclk);
      check("oe short low", 16'(plane_oe), 16'h0001);
    end
    @(posedge mclk);
    osc_in <= 1'b0;
    repeat (20) @(negedge mclk);
    check("oe slave", 16'(plane_oe), 16'h0000);
    // External plane no faster than the device's own rate
    for (int b = 1; b >= 0; b--) begin
      @(posedge mclk);
      ext_plane <= b[0];
      repeat (OSC_H * OSC_DIV) @(negedge mclk);
      for (int i = 0; i < 4; i++) check("slave digit", 16'(dig[i] ^ {7{b[0]}}), 16'(exp_dig[i]));
    end
    @(posedge mclk);
    osc_in <= 1'b1;
    repeat (20) @(negedge mclk);
    check("oe master", 16'(plane_oe), 16'h0001);
    $display("test plane done");
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    exp_dig = '{default: SEG_RESET};
    check_digits();
    check("oe after reset", 16'(plane_oe), 16'h0001);
    $display("test second reset done");
    end_of_test();
  end
endmodule : fdlcd_core_tb
`default_nettype wire
